// *** verilog/iso_context_irq_regs.sv ***
// Isochronous transmit and receive context interrupt event and mask
// registers, with the aggregate and gated interrupt outputs.
// Assumes an APB master on I_CLK and DMA context engines on I_CLK.
module iso_context_irq_regs #(
	parameter int TX_N = iso_irq_pkg::TX_CTX_N,
	parameter int RX_N = iso_irq_pkg::RX_CTX_N
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [iso_irq_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [iso_irq_pkg::DATA_W-1:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [iso_irq_pkg::DATA_W-1:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// DMA context completions
	input wire iso_irq_pkg::tx_cmp_t I_TX_CMP,
	input wire iso_irq_pkg::rx_cmp_t I_RX_CMP,
	// Interrupt outputs
	output logic O_AGG_TX_DMA_IRQ,
	output logic O_AGG_RX_DMA_IRQ,
	output logic O_IRQ
);

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_ACCESS
	} apb_state_t;

	apb_state_t state_r;
	apb_state_t state_nxt;
	iso_irq_pkg::reg_sel_t sel_r;
	iso_irq_pkg::reg_sel_t sel_nxt;

	logic [TX_N-1:0] tx_level;
	logic [RX_N-1:0] rx_level;
	logic [TX_N-1:0] tx_event;
	logic [TX_N-1:0] tx_mask;
	logic [RX_N-1:0] rx_event;
	logic [RX_N-1:0] rx_mask;
	logic [TX_N-1:0] tx_ev_set;
	logic [TX_N-1:0] tx_ev_clr;
	logic [TX_N-1:0] tx_mk_set;
	logic [TX_N-1:0] tx_mk_clr;
	logic [RX_N-1:0] rx_ev_set;
	logic [RX_N-1:0] rx_ev_clr;
	logic [RX_N-1:0] rx_mk_set;
	logic [RX_N-1:0] rx_mk_clr;

	logic global_irq_gate_r;
	logic main_mask_tx_r;
	logic main_mask_rx_r;

	logic setup;
	logic wr_done;
	logic [iso_irq_pkg::DATA_W-1:0] wdata;
	logic [iso_irq_pkg::DATA_W-1:0] rdata_nxt;
	logic agg_tx_nxt;
	logic agg_rx_nxt;
	logic irq_nxt;

	// Interrupt control field requests an interrupt
	function automatic logic ctl_requests(input logic [iso_irq_pkg::CTL_W-1:0] ctl);
		ctl_requests = (ctl == iso_irq_pkg::CTL_IRQ_ALWAYS);
	endfunction : ctl_requests

	// Byte strobes expanded to a bit mask
	function automatic logic [iso_irq_pkg::DATA_W-1:0] strb_mask(input logic [3:0] strb);
		logic [iso_irq_pkg::DATA_W-1:0] m;
		m = '0;
		for (int b = 0; b < 4; b++)
		begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		strb_mask = m;
	endfunction : strb_mask

	// Address to register select
	function automatic iso_irq_pkg::reg_sel_t decode(
		input logic [iso_irq_pkg::ADDR_W-1:0] a
	);
		case (a)
			iso_irq_pkg::OFS_TX_EVENT_SET: decode = iso_irq_pkg::SEL_TX_EV_SET;
			iso_irq_pkg::OFS_TX_EVENT_CLEAR: decode = iso_irq_pkg::SEL_TX_EV_CLR;
			iso_irq_pkg::OFS_TX_MASK_SET: decode = iso_irq_pkg::SEL_TX_MK_SET;
			iso_irq_pkg::OFS_TX_MASK_CLEAR: decode = iso_irq_pkg::SEL_TX_MK_CLR;
			iso_irq_pkg::OFS_RX_EVENT_SET: decode = iso_irq_pkg::SEL_RX_EV_SET;
			iso_irq_pkg::OFS_RX_EVENT_CLEAR: decode = iso_irq_pkg::SEL_RX_EV_CLR;
			iso_irq_pkg::OFS_RX_MASK_SET: decode = iso_irq_pkg::SEL_RX_MK_SET;
			iso_irq_pkg::OFS_RX_MASK_CLEAR: decode = iso_irq_pkg::SEL_RX_MK_CLR;
			iso_irq_pkg::OFS_IRQ_CTRL: decode = iso_irq_pkg::SEL_CTRL;
			iso_irq_pkg::OFS_IRQ_STATUS: decode = iso_irq_pkg::SEL_STATUS;
			default: decode = iso_irq_pkg::SEL_NONE;
		endcase
	endfunction : decode

	// Completion levels; a context holding done for several cycles still
	// yields one event because the bank sets on the rising edge only
	always_comb
	begin
		for (int i = 0; i < TX_N; i++)
		begin
			tx_level[i] = I_TX_CMP.done[i] & I_TX_CMP.out_last[i]
				& ctl_requests(I_TX_CMP.irq_ctl[i*iso_irq_pkg::CTL_W +: iso_irq_pkg::CTL_W]);
		end
	end

	always_comb
	begin
		for (int i = 0; i < RX_N; i++)
		begin
			rx_level[i] = I_RX_CMP.done[i] & I_RX_CMP.is_input[i]
				& ctl_requests(I_RX_CMP.irq_ctl[i*iso_irq_pkg::CTL_W +: iso_irq_pkg::CTL_W]);
		end
	end

	// APB handshake: no wait state; every bus output is a flip-flop loaded at the end of the setup cycle
	assign setup = I_PSEL & ~I_PENABLE;
	assign wr_done = (state_r == ST_ACCESS) & I_PSEL & I_PENABLE & I_PWRITE;
	assign wdata = I_PWDATA & strb_mask(I_PSTRB);

	always_comb
	begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		case (state_r)
			ST_IDLE:
			begin
				if (setup)
				begin
					state_nxt = ST_ACCESS;
					sel_nxt = decode(I_PADDR);
				end
			end
			ST_ACCESS:
			begin
				state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			sel_r <= iso_irq_pkg::SEL_NONE;
		else
			sel_r <= sel_nxt;
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_PREADY <= 1'b0;
		else
			O_PREADY <= (state_r == ST_IDLE) & setup;
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_PSLVERR <= 1'b0;
		else if ((state_r == ST_IDLE) & setup)
			O_PSLVERR <= (decode(I_PADDR) == iso_irq_pkg::SEL_NONE);
		else
			O_PSLVERR <= 1'b0;
	end

	// Write strobes, one-hot per port; writing zero changes nothing
	always_comb
	begin
		tx_ev_set = '0;
		tx_ev_clr = '0;
		tx_mk_set = '0;
		tx_mk_clr = '0;
		rx_ev_set = '0;
		rx_ev_clr = '0;
		rx_mk_set = '0;
		rx_mk_clr = '0;
		if (wr_done)
		begin
			case (sel_r)
				iso_irq_pkg::SEL_TX_EV_SET: tx_ev_set = wdata[TX_N-1:0];
				iso_irq_pkg::SEL_TX_EV_CLR: tx_ev_clr = wdata[TX_N-1:0];
				iso_irq_pkg::SEL_TX_MK_SET: tx_mk_set = wdata[TX_N-1:0];
				iso_irq_pkg::SEL_TX_MK_CLR: tx_mk_clr = wdata[TX_N-1:0];
				iso_irq_pkg::SEL_RX_EV_SET: rx_ev_set = wdata[RX_N-1:0];
				iso_irq_pkg::SEL_RX_EV_CLR: rx_ev_clr = wdata[RX_N-1:0];
				iso_irq_pkg::SEL_RX_MK_SET: rx_mk_set = wdata[RX_N-1:0];
				iso_irq_pkg::SEL_RX_MK_CLR: rx_mk_clr = wdata[RX_N-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Main control bits, kept here since the main registers live elsewhere
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			global_irq_gate_r <= 1'b0;
			main_mask_tx_r <= 1'b0;
			main_mask_rx_r <= 1'b0;
		end
		else if (wr_done && sel_r == iso_irq_pkg::SEL_CTRL)
		begin
			global_irq_gate_r <= wdata[iso_irq_pkg::BIT_GLOBAL_GATE];
			main_mask_tx_r <= wdata[iso_irq_pkg::BIT_AGG_TX];
			main_mask_rx_r <= wdata[iso_irq_pkg::BIT_AGG_RX];
		end
	end

	iso_w1sc_bits #(
		.W(TX_N),
		.RST_VAL(iso_irq_pkg::TX_EVENT_RST)
	) u_tx_event (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_level(tx_level),
		.i_set(tx_ev_set),
		.i_clr(tx_ev_clr),
		.o_bits(tx_event)
	);

	iso_w1sc_bits #(
		.W(TX_N),
		.RST_VAL(iso_irq_pkg::TX_MASK_RST)
	) u_tx_mask (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_level('0),
		.i_set(tx_mk_set),
		.i_clr(tx_mk_clr),
		.o_bits(tx_mask)
	);

	iso_w1sc_bits #(
		.W(RX_N),
		.RST_VAL(iso_irq_pkg::RX_EVENT_RST)
	) u_rx_event (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_level(rx_level),
		.i_set(rx_ev_set),
		.i_clr(rx_ev_clr),
		.o_bits(rx_event)
	);

	iso_w1sc_bits #(
		.W(RX_N),
		.RST_VAL(iso_irq_pkg::RX_MASK_RST)
	) u_rx_mask (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_level('0),
		.i_set(rx_mk_set),
		.i_clr(rx_mk_clr),
		.o_bits(rx_mask)
	);

	// Read data is captured in the setup cycle; an event arriving during
	// the access cycle shows on the next read
	always_comb
	begin
		rdata_nxt = iso_irq_pkg::RDATA_RST;
		case (decode(I_PADDR))
			iso_irq_pkg::SEL_TX_EV_SET: rdata_nxt[TX_N-1:0] = tx_event;
			iso_irq_pkg::SEL_TX_EV_CLR: rdata_nxt[TX_N-1:0] = tx_event & tx_mask;
			iso_irq_pkg::SEL_TX_MK_SET,
			iso_irq_pkg::SEL_TX_MK_CLR: rdata_nxt[TX_N-1:0] = tx_mask;
			iso_irq_pkg::SEL_RX_EV_SET: rdata_nxt[RX_N-1:0] = rx_event;
			iso_irq_pkg::SEL_RX_EV_CLR: rdata_nxt[RX_N-1:0] = rx_event & rx_mask;
			iso_irq_pkg::SEL_RX_MK_SET,
			iso_irq_pkg::SEL_RX_MK_CLR: rdata_nxt[RX_N-1:0] = rx_mask;
			iso_irq_pkg::SEL_CTRL:
			begin
				rdata_nxt[iso_irq_pkg::BIT_GLOBAL_GATE] = global_irq_gate_r;
				rdata_nxt[iso_irq_pkg::BIT_AGG_TX] = main_mask_tx_r;
				rdata_nxt[iso_irq_pkg::BIT_AGG_RX] = main_mask_rx_r;
			end
			iso_irq_pkg::SEL_STATUS:
			begin
				rdata_nxt[iso_irq_pkg::BIT_GLOBAL_GATE] = O_IRQ;
				rdata_nxt[iso_irq_pkg::BIT_AGG_TX] = O_AGG_TX_DMA_IRQ;
				rdata_nxt[iso_irq_pkg::BIT_AGG_RX] = O_AGG_RX_DMA_IRQ;
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_PRDATA <= iso_irq_pkg::RDATA_RST;
		else if ((state_r == ST_IDLE) & setup & ~I_PWRITE)
			O_PRDATA <= rdata_nxt;
		else if (state_r == ST_ACCESS)
			O_PRDATA <= O_PRDATA;
		else
			O_PRDATA <= iso_irq_pkg::RDATA_RST;
	end

	// Aggregates and the gated interrupt, computed from the next event
	// state would cost more logic; one cycle of latency is accepted
	assign agg_tx_nxt = |(tx_event & tx_mask);
	assign agg_rx_nxt = |(rx_event & rx_mask);
	assign irq_nxt = global_irq_gate_r
		& ((agg_tx_nxt & main_mask_tx_r)
		| (agg_rx_nxt & main_mask_rx_r));

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_AGG_TX_DMA_IRQ <= 1'b0;
			O_AGG_RX_DMA_IRQ <= 1'b0;
		end
		else
		begin
			O_AGG_TX_DMA_IRQ <= agg_tx_nxt;
			O_AGG_RX_DMA_IRQ <= agg_rx_nxt;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			O_IRQ <= 1'b0;
		else
			O_IRQ <= irq_nxt;
	end

endmodule : iso_context_irq_regs

// *** verilog/iso_irq_pkg.sv ***
// Constants, register map and carrier types for the isochronous context
// interrupt registers. Assumes a 32-bit APB register bus and 8-bit offsets.
package iso_irq_pkg;

	localparam int TX_CTX_N = 8;
	localparam int RX_CTX_N = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CTL_W = 2;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_TX_EVENT_SET = 8'h90;
	localparam logic [ADDR_W-1:0] OFS_TX_EVENT_CLEAR = 8'h94;
	localparam logic [ADDR_W-1:0] OFS_TX_MASK_SET = 8'h98;
	localparam logic [ADDR_W-1:0] OFS_TX_MASK_CLEAR = 8'h9c;
	localparam logic [ADDR_W-1:0] OFS_RX_EVENT_SET = 8'ha0;
	localparam logic [ADDR_W-1:0] OFS_RX_EVENT_CLEAR = 8'ha4;
	localparam logic [ADDR_W-1:0] OFS_RX_MASK_SET = 8'ha8;
	localparam logic [ADDR_W-1:0] OFS_RX_MASK_CLEAR = 8'hac;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 8'hc0;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'hc4;

	// Field positions in the control and status words
	localparam int BIT_AGG_TX = 6;
	localparam int BIT_AGG_RX = 7;
	localparam int BIT_GLOBAL_GATE = 31;

	// Reset values
	localparam logic [TX_CTX_N-1:0] TX_EVENT_RST = 8'h00;
	localparam logic [TX_CTX_N-1:0] TX_MASK_RST = 8'h00;
	localparam logic [RX_CTX_N-1:0] RX_EVENT_RST = 4'h0;
	localparam logic [RX_CTX_N-1:0] RX_MASK_RST = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// Interrupt control field value that requests an interrupt
	localparam logic [CTL_W-1:0] CTL_IRQ_ALWAYS = 2'h3;

	// Completion report of the transmit contexts, one bit or field per context
	typedef struct packed {
		logic [TX_CTX_N-1:0] done;
		logic [TX_CTX_N-1:0] out_last;
		logic [TX_CTX_N*CTL_W-1:0] irq_ctl;
	} tx_cmp_t;

	// Completion report of the receive contexts
	typedef struct packed {
		logic [RX_CTX_N-1:0] done;
		logic [RX_CTX_N-1:0] is_input;
		logic [RX_CTX_N*CTL_W-1:0] irq_ctl;
	} rx_cmp_t;

	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_TX_EV_SET,
		SEL_TX_EV_CLR,
		SEL_TX_MK_SET,
		SEL_TX_MK_CLR,
		SEL_RX_EV_SET,
		SEL_RX_EV_CLR,
		SEL_RX_MK_SET,
		SEL_RX_MK_CLR,
		SEL_CTRL,
		SEL_STATUS
	} reg_sel_t;

endpackage : iso_irq_pkg

// *** verilog/iso_w1sc_bits.sv ***
// Bank of sticky bits with rising-edge hardware set, write-one set and
// write-one clear. Assumes all inputs are on the I_CLK domain.
module iso_w1sc_bits #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Set and clear sources
	input wire logic [W-1:0] i_level,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	// Stored bits
	output logic [W-1:0] o_bits
);

	logic [W-1:0] level_r;
	logic [W-1:0] bits_nxt;

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			level_r <= '0;
		else
			level_r <= i_level;
	end

	// A set in the clear cycle wins so no event is lost
	always_comb
	begin
		bits_nxt = o_bits & ~i_clr;
		bits_nxt = bits_nxt | i_set | (i_level & ~level_r);
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			o_bits <= RST_VAL;
		else
			o_bits <= bits_nxt;
	end

endmodule : iso_w1sc_bits

// *** verification/iso_dma_model.sv ***
// Model of the isochronous DMA context engines.
// Assumes the bench calls its tasks between register accesses.
module iso_dma_model (
	// Clock
	input wire logic i_clk,
	// Completion reports
	output iso_irq_pkg::tx_cmp_t o_tx,
	output iso_irq_pkg::rx_cmp_t o_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_tx = '0;
	initial o_rx = '0;
	// Stale qualifiers are flipped on the same edge that done drops: nothing may lean on them
	task automatic tx_done(input int c, input logic ol, input logic [1:0] ctl, input int hold);
		@(posedge i_clk);
		o_tx.done[c] <= 1'b1;
		o_tx.out_last[c] <= ol;
		o_tx.irq_ctl[2*c+:2] <= ctl;
		repeat (hold) @(posedge i_clk);
		o_tx.done[c] <= 1'b0;
		o_tx.out_last[c] <= ~ol;
		o_tx.irq_ctl[2*c+:2] <= ~ctl;
	endtask : tx_done
	task automatic rx_done(input int c, input logic ii, input logic [1:0] ctl, input int hold);
		@(posedge i_clk);
		o_rx.done[c] <= 1'b1;
		o_rx.is_input[c] <= ii;
		o_rx.irq_ctl[2*c+:2] <= ctl;
		repeat (hold) @(posedge i_clk);
		o_rx.done[c] <= 1'b0;
		o_rx.is_input[c] <= ~ii;
		o_rx.irq_ctl[2*c+:2] <= ~ctl;
	endtask : rx_done
endmodule : iso_dma_model

// *** verification/iso_context_irq_regs_properties.sv ***
// Port checker for the isochronous context interrupt registers.
// Assumes one clock and the one-cycle APB access of the design.
module iso_irq_checker #(
	parameter int TX_N = 8,
	parameter int RX_N = 4
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// APB
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	// Interrupts
	input wire logic O_AGG_TX_DMA_IRQ,
	input wire logic O_AGG_RX_DMA_IRQ,
	input wire logic O_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	logic wr;
	logic rd;
	assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB == 4'hf;
	assign rd = O_PREADY && !I_PWRITE;
	property p_tx_rsv;
		rd && I_PADDR inside {8'h90, 8'h94, 8'h98, 8'h9c} |-> O_PRDATA[31:TX_N] == '0;
	endproperty
	a_tx_rsv: assert property (p_tx_rsv) else $error("tx reserved bits set");
	property p_rx_rsv;
		rd && I_PADDR inside {8'ha0, 8'ha4, 8'ha8, 8'hac} |-> O_PRDATA[31:RX_N] == '0;
	endproperty
	a_rx_rsv: assert property (p_rx_rsv) else $error("rx reserved bits set");
	property p_tx_stick;
		O_AGG_TX_DMA_IRQ && !$past(wr && I_PADDR inside {8'h94, 8'h9c}) |=> O_AGG_TX_DMA_IRQ;
	endproperty
	a_tx_stick: assert property (p_tx_stick) else $error("tx event lost");
	property p_rx_stick;
		O_AGG_RX_DMA_IRQ && !$past(wr && I_PADDR inside {8'ha4, 8'hac}) |=> O_AGG_RX_DMA_IRQ;
	endproperty
	a_rx_stick: assert property (p_rx_stick) else $error("rx event lost");
	property p_tx_off;
		wr && I_PADDR == 8'h9c && I_PWDATA[TX_N-1:0] == '1 |-> ##2 !O_AGG_TX_DMA_IRQ;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx mask clear");
	property p_rx_off;
		wr && I_PADDR == 8'hac && I_PWDATA[RX_N-1:0] == '1 |-> ##2 !O_AGG_RX_DMA_IRQ;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx mask clear");
	property p_gate;
		wr && I_PADDR == 8'hc0 && !I_PWDATA[31] |-> ##2 !O_IRQ;
	endproperty
	a_gate: assert property (p_gate) else $error("irq while gated");
	property p_irq;
		O_IRQ |-> O_AGG_TX_DMA_IRQ || O_AGG_RX_DMA_IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	c_irq: cover property (O_IRQ ##1 !O_IRQ);
	c_tx: cover property (O_AGG_TX_DMA_IRQ);
	c_rx: cover property (O_AGG_RX_DMA_IRQ);
endmodule : iso_irq_checker
bind iso_context_irq_regs iso_irq_checker #(.TX_N(TX_N), .RX_N(RX_N)) chk_u (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_AGG_TX_DMA_IRQ(O_AGG_TX_DMA_IRQ),
	.O_AGG_RX_DMA_IRQ(O_AGG_RX_DMA_IRQ), .O_IRQ(O_IRQ));

// *** verification/tb.sv ***
// Self-checking bench for the isochronous context interrupt registers.
// Assumes the DMA model and an APB master made of tasks.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, rd_q, r, seed = 32'd8990;
	logic [31:0] tx_ev, tx_mk, rx_ev, rx_mk, ctrl;
	logic pready, pslverr, agg_tx, agg_rx, irq, err_q;
	iso_irq_pkg::tx_cmp_t tx_cmp;
	iso_irq_pkg::rx_cmp_t rx_cmp;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	// Last entry is unmapped
	logic [7:0] tbl [10] = '{8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hc0, 8'h10};
	logic [7:0] seq [10] = '{8'hc0, 8'h90, 8'h98, 8'ha0, 8'ha8, 8'h94, 8'h90, 8'h9c, 8'hc0, 8'hac};
	always #2.5 clk = ~clk;
	iso_context_irq_regs dut_u (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TX_CMP(tx_cmp),
		.I_RX_CMP(rx_cmp), .O_AGG_TX_DMA_IRQ(agg_tx), .O_AGG_RX_DMA_IRQ(agg_rx), .O_IRQ(irq));
	iso_dma_model dma_u (.i_clk(clk), .o_tx(tx_cmp), .o_rx(rx_cmp));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Status word doubles as the expected aggregate and gated interrupt levels
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		logic at;
		logic ar;
		at = |(tx_ev & tx_mk);
		ar = |(rx_ev & rx_mk);
		case (a)
			8'h90: return tx_ev;
			8'h94: return tx_ev & tx_mk;
			8'h98, 8'h9c: return tx_mk;
			8'ha0: return rx_ev;
			8'ha4: return rx_ev & rx_mk;
			8'ha8, 8'hac: return rx_mk;
			8'hc0: return ctrl;
			8'hc4: return {ctrl[31] & (at & ctrl[6] | ar & ctrl[7]), 23'h0, ar, at, 6'h0};
			default: return 32'h0;
		endcase
	endfunction : exp_rd
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		x = exp_rd(a);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk);
		while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		case (w ? a : 8'h00)
			8'h90: tx_ev |= d & 32'hff;
			8'h94: tx_ev &= ~d;
			8'h98: tx_mk |= d & 32'hff;
			8'h9c: tx_mk &= ~d;
			8'ha0: rx_ev |= d & 32'hf;
			8'ha4: rx_ev &= ~d;
			8'ha8: rx_mk |= d & 32'hf;
			8'hac: rx_mk &= ~d;
			8'hc0: ctrl = d & 32'h8000_00c0;
			default: cmp(rd_q, x);
		endcase
		cmp_bit(err_q, a == 8'h10);
	endtask : access
	task automatic chk_irq();
		logic [31:0] s;
		repeat (2) @(posedge clk);
		s = exp_rd(8'hc4);
		cmp_bit(agg_tx, s[6]);
		cmp_bit(agg_rx, s[7]);
		cmp_bit(irq, s[31]);
	endtask : chk_irq
	// Model is cleared with the design so later reads start from zero
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		{tx_ev, tx_mk, rx_ev, rx_mk, ctrl} = '0;
		foreach (tbl[i])
			access(1'b0, tbl[i], 32'h0);
		$display("reset test done");
	endtask : do_reset
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			conclude();
		end
	end
	initial
	begin
		do_reset();
		for (int i = 0; i < 300; i++)
		begin
			r = rnd();
			if (r[1:0] == 2'd0)
			begin
				dma_u.tx_done(r[4:2], r[5], r[7:6], r[9:8] + 1);
				tx_ev |= (r[5] && r[7:6] == 2'b11) << r[4:2];
			end
			else if (r[1:0] == 2'd1)
			begin
				dma_u.rx_done(r[3:2], r[5], r[7:6], r[9:8] + 1);
				rx_ev |= (r[5] && r[7:6] == 2'b11) << r[3:2];
			end
			else
				access(1'b1, tbl[r[11:8] % 10], rnd());
			access(1'b0, tbl[r[15:12] % 10], 32'h0);
			chk_irq();
		end
		$display("random test done");
		do_reset();
		foreach (seq[i])
		begin
			access(1'b1, seq[i], i == 8 ? 32'h0 : 32'hffff_ffff);
			chk_irq();
			access(1'b0, 8'hc4, 32'h0);
			access(1'b0, 8'h94, 32'h0);
			access(1'b0, 8'ha4, 32'h0);
		end
		$display("mask and gate test done");
		conclude();
	end
endmodule : tb
